// >>> hdl/cci_config_status.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cci_defines.svh"

module cci_config_status #(
  parameter int CHANNELS = 16,
  parameter int ADR_W = 8,
  parameter int TICK_CYCLES = `CCI_TICK_CYCLES,
  parameter int SETTLE_TICKS = `CCI_SETTLE_TICKS,
  parameter int WDOG_CYCLES = `CCI_WDOG_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire cci_pkg::cci_word_t wb_dat_i,
  output cci_pkg::cci_word_t wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // field monitors
  input wire logic [15:0] contact_i,
  input wire logic aux_fail_i,
  input wire logic gnd_fault_i,
  // indicators and attention
  output logic attention_o,
  output logic comm_led_o,
  output logic ext_fault_led_o,
  output logic int_fault_led_o,
  output logic [15:0] channel_point_indicators_o
);
  import cci_pkg::*;

  if (CHANNELS != 16 || ADR_W < 8 || TICK_CYCLES < 1 || TICK_CYCLES > 131071 ||
      SETTLE_TICKS < 1 || SETTLE_TICKS > 7 || WDOG_CYCLES < 2) begin : g_bad_param
    $error("cci_config_status: unsupported parameter value");
  end

  function automatic logic hits(input logic [ADR_W-1:0] adr, input logic [5:0] idx);
    hits = (adr[1:0] == 2'h0) && (adr[ADR_W-1:2] == {{(ADR_W-8){1'b0}}, idx});
  endfunction : hits

  cci_state_t st_reg;
  cci_state_t st_next;
  logic req;
  logic hit_cfg;
  logic hit_pts;
  logic [15:0] status_word;

  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
  assign hit_cfg = hits(wb_adr_i, `CCI_IDX_CFG_STAT);
  assign hit_pts = hits(wb_adr_i, `CCI_IDX_POINTS);

  always_comb begin
    status_word = `CCI_STAT_ONES;
    status_word[`CCI_BIT_CONFIGURED] = st_reg.cfg;
    status_word[`CCI_BIT_FORCE_ERR] = st_reg.force_err;
    status_word[`CCI_BIT_AUX_FAIL] = st_reg.aux;
    status_word[`CCI_BIT_GF_ATTN_EN] = st_reg.gf_en;
    status_word[`CCI_BIT_GND_FAULT] = st_reg.gnd;
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    st_next.gnd = gnd_fault_i;
    st_next.aux = aux_fail_i;

    // contact filter on a shared millisecond tick
    if (st_reg.tick >= 17'(TICK_CYCLES - 1)) begin
      st_next.tick = 17'h00000;
    end else begin
      st_next.tick = st_reg.tick + 17'h00001;
    end
    for (int i = 0; i < 16; i++) begin
      if (contact_i[i] == st_reg.pts[i]) begin
        st_next.cnt[i] = 3'h0;
      end else if (st_reg.tick == 17'h00000) begin
        if (st_reg.cnt[i] >= 3'(SETTLE_TICKS - 1)) begin
          st_next.pts[i] = contact_i[i];
          st_next.cnt[i] = 3'h0;
        end else begin
          st_next.cnt[i] = st_reg.cnt[i] + 3'h1;
        end
      end
    end

    // communication watchdog
    if (req) begin
      st_next.wd = 32'h00000000;
      st_next.wd_to = 1'b0;
      st_next.seen = 1'b1;
    end else if (st_reg.wd >= 32'(WDOG_CYCLES - 1)) begin
      st_next.wd_to = 1'b1;
    end else begin
      st_next.wd = st_reg.wd + 32'h00000001;
    end

    // bus answers one cycle after the request
    if (req) begin
      st_next.dat = 32'h00000000;
      if (hit_cfg) begin
        st_next.ack = 1'b1;
        if (wb_we_i) begin
          if (wb_sel_i[0]) begin
            st_next.cfg = wb_dat_i[`CCI_BIT_CONFIGURED];
            st_next.force_err = wb_dat_i[`CCI_BIT_FORCE_ERR];
          end
          if (wb_sel_i[1]) begin
            st_next.gf_en = wb_dat_i[`CCI_BIT_GF_ATTN_EN];
          end
        end else begin
          st_next.dat = {16'h0000, status_word};
        end
      end else if (hit_pts && !wb_we_i) begin
        if (st_reg.attn) begin
          st_next.err = 1'b1;
        end else begin
          st_next.ack = 1'b1;
          st_next.dat = {16'h0000, st_reg.pts};
        end
      end else begin
        st_next.err = 1'b1;
      end
    end

    st_next.int_led = st_reg.force_err || st_reg.aux || st_reg.wd_to;
    st_next.attn = !st_reg.cfg || st_reg.force_err || st_reg.aux || st_reg.wd_to ||
      (st_reg.gf_en && st_reg.gnd);
    st_next.comm_led = st_reg.seen && !st_reg.wd_to;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.cfg <= `CCI_RESET_CFG;
      st_reg.attn <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign wb_err_o = st_reg.err;
  assign attention_o = st_reg.attn;
  assign comm_led_o = st_reg.comm_led;
  assign ext_fault_led_o = st_reg.gnd;
  assign int_fault_led_o = st_reg.int_led;
  assign channel_point_indicators_o = st_reg.pts;

  // status read returns stored bits, fixed ones and zeros
  a_status_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg && !wb_we_i) |=> wb_ack_o && wb_dat_o[5:2] == 4'hf &&
      wb_dat_o[15:11] == 5'h1f && wb_dat_o[7:6] == 2'h0 && wb_dat_o[31:16] == 16'h0000 &&
      wb_dat_o[1:0] == {$past(st_reg.force_err), $past(st_reg.cfg)})
    else $error("status word content wrong");

  a_cfg_write_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg && wb_we_i && wb_sel_i[1:0] == 2'h3) |=>
      st_reg.cfg == $past(wb_dat_i[0]) && st_reg.force_err == $past(wb_dat_i[1]) &&
      st_reg.gf_en == $past(wb_dat_i[9]))
    else $error("configuration write not stored");

  a_unconf_attn: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !st_reg.cfg |=> attention_o)
    else $error("unconfigured without attention");

  a_gnd_led: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gnd_fault_i |=> ext_fault_led_o)
    else $error("external fault indicator wrong");

  a_gf_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.gf_en && st_reg.gnd) |=> attention_o)
    else $error("ground fault did not raise attention");

  a_pts_refused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_pts && !wb_we_i && st_reg.attn) |=> wb_err_o && !wb_ack_o)
    else $error("point data delivered under attention");

  a_gf_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!st_reg.gf_en && st_reg.cfg && !st_reg.force_err && !st_reg.aux && !st_reg.wd_to)
      |=> !attention_o)
    else $error("masked ground fault raised attention");

  a_int_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.force_err || st_reg.aux) |=> int_fault_led_o && attention_o)
    else $error("internal fault not indicated");

  a_wdog_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req |=> st_reg.wd == 32'h00000000 && !st_reg.wd_to ##1 comm_led_o)
    else $error("watchdog not restarted by access");

  a_pts_settle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(st_reg.pts) |-> $past(st_reg.tick) == 17'h00000)
    else $error("point changed off the filter tick");

  a_one_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer held longer than one cycle");

  // point reads refused until the module is configured
  a_unconf_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_pts && !wb_we_i && !st_reg.cfg)
      |=> wb_err_o && !wb_ack_o)
    else $error("point data delivered while unconfigured");

  a_force_attn: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.force_err
      |=> attention_o)
    else $error("forced error without attention");

  a_aux_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg && !wb_we_i)
      |=> wb_dat_o[8] == $past(st_reg.aux))
    else $error("auxiliary failure bit wrong");

  a_gf_en_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg && !wb_we_i)
      |=> wb_dat_o[9] == $past(st_reg.gf_en))
    else $error("ground fault enable bit wrong");

  a_gnd_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg && !wb_we_i)
      |=> wb_dat_o[10] == $past(st_reg.gnd))
    else $error("ground fault bit wrong");

  a_pts_deliver: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_pts && !wb_we_i && !st_reg.attn)
      |=> wb_ack_o && wb_dat_o[15:0] == $past(st_reg.pts))
    else $error("point data not delivered");

  a_bad_index: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && !hit_cfg && !hit_pts)
      |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");

  a_cfg_acked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg)
      |=> wb_ack_o && !wb_err_o)
    else $error("status index access not acknowledged");

  a_write_no_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && wb_we_i)
      |=> wb_dat_o == 32'h00000000)
    else $error("write returned data");

  a_wdog_timeout: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.wd_to
      |=> int_fault_led_o && attention_o)
    else $error("watchdog timeout not indicated");

  a_comm_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.wd_to
      |=> !comm_led_o)
    else $error("comms indicator lit after timeout");

  a_bounce_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (contact_i[0] == st_reg.pts[0])
      |=> st_reg.cnt[0] == 3'h0)
    else $error("filter count kept after bounce");

  a_pts_accept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.tick == 17'h00000 && st_reg.cnt[0] == 3'(SETTLE_TICKS - 1) && contact_i[0] != st_reg.pts[0])
      |=> channel_point_indicators_o[0] == $past(contact_i[0]))
    else $error("settled contact not accepted");

  a_fixed_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req && hit_cfg && !wb_we_i)
      |=> wb_dat_o[15:11] == 5'h1f && wb_dat_o[5:2] == 4'hf)
    else $error("undefined status bits not high");

endmodule : cci_config_status

// >>> hdl/cci_defines.svh
`ifndef CCI_DEFINES_SVH
`define CCI_DEFINES_SVH

// register indices; byte address is four times the index
`define CCI_IDX_POINTS 6'h00
`define CCI_IDX_CFG_STAT 6'h0d

// configuration and status bit positions
`define CCI_BIT_CONFIGURED 0
`define CCI_BIT_FORCE_ERR 1
`define CCI_BIT_AUX_FAIL 8
`define CCI_BIT_GF_ATTN_EN 9
`define CCI_BIT_GND_FAULT 10

// undefined status bits 2-5 and 11-15 read high
`define CCI_STAT_ONES 16'hf83c
`define CCI_RESET_CFG 1'b0

// timing
`define CCI_CLK_PERIOD_NS 8
`define CCI_TICK_NS 1000000
`define CCI_REJECT_MS 3
`define CCI_ACCEPT_MS 7
`define CCI_WDOG_MS 100
`define CCI_TICK_CYCLES ((`CCI_TICK_NS + `CCI_CLK_PERIOD_NS - 1) / `CCI_CLK_PERIOD_NS)
`define CCI_SETTLE_TICKS (`CCI_REJECT_MS + 2)
`define CCI_WDOG_CYCLES ((`CCI_WDOG_MS * `CCI_TICK_NS) / `CCI_CLK_PERIOD_NS)

`endif

// >>> hdl/cci_pkg.sv
package cci_pkg;
  typedef logic [31:0] cci_word_t;

  typedef struct packed {
    logic cfg;
    logic force_err;
    logic gf_en;
    logic gnd;
    logic aux;
    logic wd_to;
    logic seen;
    logic ack;
    logic err;
    logic attn;
    logic int_led;
    logic comm_led;
    logic [15:0] pts;
    logic [15:0][2:0] cnt;
    logic [16:0] tick;
    logic [31:0] wd;
    logic [31:0] dat;
  } cci_state_t;
endpackage : cci_pkg

// >>> verification/cci_ctrl_model.sv
`timescale 1ns/1ps
module cci_ctrl_model (
  // clock
  input wire logic clk_i,
  // bench request
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [15:0] dat_i,
  output logic done_o,
  output logic err_o,
  output logic [15:0] rd_o,
  // wishbone master
  output logic cyc_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] rdat_i,
  input wire logic ack_i,
  input wire logic err_i
);
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
    done_o = 1'b0;
  end
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (cyc_o && (ack_i || err_i)) begin
      cyc_o <= 1'b0;
      // released lines must not keep the old value
      adr_o <= ~adr_o;
      dat_o <= ~dat_o;
      rd_o <= rdat_i[15:0];
      err_o <= err_i;
      done_o <= 1'b1;
    end else if (go_i && !cyc_o && !done_o) begin
      cyc_o <= 1'b1;
      we_o <= we_i;
      adr_o <= adr_i;
      dat_o <= {16'h0, dat_i};
    end
  end
endmodule : cci_ctrl_model

// >>> verification/tb_contact_input_config_status.sv
`timescale 1ns/1ps
module tb_contact_input_config_status;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic e; logic [15:0] r; logic t;} cci_row_t;
  logic clk, rst_n, go, wr, done, er, cyc, we, ack, err, aux, gnd, attn, comm, ext, intl;
  logic [7:0] ad, adr;
  logic [15:0] wd, rd, contact, pts;
  logic [31:0] mdat;
  cci_pkg::cci_word_t sdat;
  int n_errors = 0;
  int n_checks = 0;
  cci_row_t rows [13] = '{
    '{1'b0, 8'h34, 16'h0, 1'b0, 16'hf83c, 1'b1},
    '{1'b0, 8'h00, 16'h0, 1'b1, 16'h0, 1'b1},
    '{1'b1, 8'h34, 16'h0001, 1'b0, 16'h0, 1'b0},
    '{1'b0, 8'h34, 16'h0, 1'b0, 16'hf83d, 1'b0},
    '{1'b0, 8'h00, 16'h0, 1'b0, 16'h0, 1'b0},
    '{1'b1, 8'h34, 16'hffff, 1'b0, 16'h0, 1'b1},
    '{1'b0, 8'h34, 16'h0, 1'b0, 16'hfa3f, 1'b1},
    '{1'b0, 8'h00, 16'h0, 1'b1, 16'h0, 1'b1},
    '{1'b1, 8'h34, 16'h0201, 1'b0, 16'h0, 1'b0},
    '{1'b0, 8'h34, 16'h0, 1'b0, 16'hfa3d, 1'b0},
    '{1'b0, 8'h10, 16'h0, 1'b1, 16'h0, 1'b0},
    '{1'b1, 8'h00, 16'h0, 1'b1, 16'h0, 1'b0},
    '{1'b0, 8'h35, 16'h0, 1'b1, 16'h0, 1'b0}};
  cci_ctrl_model cci_ctrl_model_i (.clk_i(clk), .go_i(go), .we_i(wr), .adr_i(ad), .dat_i(wd), .done_o(done),
    .err_o(er), .rd_o(rd), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(mdat), .rdat_i(sdat), .ack_i(ack),
    .err_i(err));
  cci_config_status #(.TICK_CYCLES(4), .SETTLE_TICKS(5), .WDOG_CYCLES(50)) cci_config_status_i (.clk_i(clk),
    .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(mdat), .wb_dat_o(sdat), .wb_ack_o(ack), .wb_err_o(err), .contact_i(contact), .aux_fail_i(aux),
    .gnd_fault_i(gnd), .attention_o(attn), .comm_led_o(comm), .ext_fault_led_o(ext), .int_fault_led_o(intl),
    .channel_point_indicators_o(pts));
  always #4 clk = ~clk;
  task automatic print_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(negedge clk); while (done !== 1'b1 && n++ < 40);
    chk("done", done, 1'b1);
    @(posedge clk);
    go <= 1'b0;
  endtask : bus
  initial begin
    #40000;
    n_errors++;
    print_verdict();
  end
  initial begin
    clk = 0; rst_n = 0; go = 0; wr = 0; ad = 0; wd = 0; contact = 0; aux = 0; gnd = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("attn", attn, 1'b1);
    chk("pts", pts, 16'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      chk("err", er, rows[i].e);
      if (!rows[i].w && !rows[i].e) chk("rdat", rd, rows[i].r);
      chk("attn", attn, rows[i].t);
    end
    @(posedge clk);
    aux <= 1'b1;
    repeat (3) @(negedge clk);
    chk("int_led", intl, 1'b1);
    chk("attn", attn, 1'b1);
    bus(1'b0, 8'h34, 16'h0);
    chk("stat", rd, 16'hfb3d);
    @(posedge clk);
    aux <= 1'b0;
    gnd <= 1'b1;
    repeat (3) @(negedge clk);
    chk("ext_led", ext, 1'b1);
    chk("attn", attn, 1'b1);
    bus(1'b0, 8'h00, 16'h0);
    chk("err", er, 1'b1);
    bus(1'b0, 8'h34, 16'h0);
    chk("stat", rd, 16'hfe3d);
    bus(1'b1, 8'h34, 16'h0001);
    bus(1'b0, 8'h00, 16'h0);
    chk("err", er, 1'b0);
    chk("attn", attn, 1'b0);
    chk("ext_led", ext, 1'b1);
    @(posedge clk);
    gnd <= 1'b0;
    contact <= 16'h8001;
    repeat (28) @(negedge clk);
    chk("pts", pts, 16'h8001);
    bus(1'b0, 8'h00, 16'h0);
    chk("rdat", rd, 16'h8001);
    @(posedge clk);
    contact <= 16'h0;
    repeat (2) @(posedge clk);
    contact <= 16'h8001;
    repeat (28) @(negedge clk);
    chk("pts", pts, 16'h8001);
    repeat (40) @(negedge clk);
    chk("int_led", intl, 1'b1);
    chk("attn", attn, 1'b1);
    chk("comm", comm, 1'b0);
    bus(1'b0, 8'h34, 16'h0);
    repeat (2) @(negedge clk);
    chk("comm", comm, 1'b1);
    chk("int_led", intl, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("attn", attn, 1'b1);
    chk("pts", pts, 16'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h34, 16'h0);
    chk("stat", rd, 16'hf83c);
    print_verdict();
  end
endmodule : tb_contact_input_config_status
